// ===== rtl/adc_acq_ctrl.sv
// Purpose: Converter acquisition control with sample queue and AHB-Lite registers
// Assumes: Converter core on SYS_CLK; trigger pins are asynchronous
// Notes:   Zero-wait-state slave; reads of the data word pop the queue
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module adc_acq_ctrl (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic      [31:0] HRDATA,
  // Trigger pins
  input  wire logic        DIO_D2,
  input  wire logic        CTR0_OUT,
  input  wire logic        CTR1_OUT,
  // Converter core
  output logic             CONV_START,
  output logic      [3:0]  CONV_CHANNEL,
  input  wire logic        CONV_DONE,
  input  wire logic [15:0] CONV_DATA,
  // Interrupt request
  output logic             ADC_IRQ
);

  typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT, S_GAP} acq_state_t;

  // Mask a bound into the range allowed by the input mode (high bits dropped)
  function automatic logic [3:0] clamp_chan(input logic [3:0] ch, input logic diff);
    clamp_chan = diff ? (ch & adc_acq_pkg::DIFF_MAX_CHAN) : (ch & adc_acq_pkg::SE_MAX_CHAN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [8:0]  ctrl_r;
  logic [3:0]  low_r;
  logic [3:0]  high_r;
  logic [7:0]  prog_r;
  logic [11:0] limit_r;
  logic        overrun_r;
  logic        event_r;
  logic        sw_start_r;

  // Bus pipeline
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] rdata_r;
  logic        addr_ok;
  logic        rd_req;
  logic        wr_req;
  logic [31:0] rdata_nxt;

  // Queue
  logic [15:0] head_data;
  logic [11:0] fill_count;
  logic        q_full;
  logic        q_empty;
  logic        q_push;
  logic        q_pop;
  logic        level_flag;

  // Acquisition
  acq_state_t  state_r;
  logic [3:0]  chan_r;
  logic [9:0]  gap_r;
  logic [4:0]  tick_cnt_r;
  logic        tick;
  logic        trig;
  logic        run;
  logic        sweep;
  logic        diff;
  logic [3:0]  low_eff;
  logic [3:0]  high_eff;
  logic        last_chan;
  logic [9:0]  step_ticks;
  logic        sample_done;
  logic        sweep_done;

  // Pin synchronisers and edge history
  logic [2:0]  pin_meta_r;
  logic [2:0]  pin_sync_r;
  logic [2:0]  pin_last_r;

  assign run      = ctrl_r[adc_acq_pkg::CTRL_RUN_BIT];
  assign sweep    = ctrl_r[adc_acq_pkg::CTRL_SWEEP_BIT];
  assign diff     = ctrl_r[adc_acq_pkg::CTRL_DIFF_BIT];
  assign low_eff  = clamp_chan(low_r, diff);
  assign high_eff = clamp_chan(high_r, diff);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: always ready, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_r;
  assign addr_ok   = HSEL && HREADY && (HTRANS == adc_acq_pkg::HTRANS_NONSEQ ||
                                        HTRANS == adc_acq_pkg::HTRANS_SEQ);
  assign rd_req    = addr_ok && !HWRITE;
  assign wr_req    = addr_ok && HWRITE;
  assign q_pop     = rd_req && (HADDR[7:0] == adc_acq_pkg::DATA_OFS);

  // Read mux, sampled in the address phase for a registered data phase
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (HADDR[7:0])
      adc_acq_pkg::CTRL_OFS:   rdata_nxt = {23'h0, ctrl_r};
      adc_acq_pkg::CHAN_OFS:   rdata_nxt = {20'h0, high_r, 4'h0, low_r};
      adc_acq_pkg::PROG_OFS:   rdata_nxt = {24'h0, prog_r};
      adc_acq_pkg::LIMIT_OFS:  rdata_nxt = {20'h0, limit_r};
      adc_acq_pkg::STATUS_OFS: begin
        rdata_nxt[adc_acq_pkg::ST_OVERRUN_BIT] = overrun_r;
        rdata_nxt[adc_acq_pkg::ST_FULL_BIT]    = q_full;
        rdata_nxt[adc_acq_pkg::ST_LEVEL_BIT]   = level_flag;
        rdata_nxt[adc_acq_pkg::ST_EMPTY_BIT]   = q_empty;
        rdata_nxt[adc_acq_pkg::ST_BUSY_BIT]    = (state_r != S_IDLE);
        rdata_nxt[adc_acq_pkg::ST_EVENT_BIT]   = event_r;
        rdata_nxt[adc_acq_pkg::ST_COUNT_LSB +: 12] = fill_count;
      end
      adc_acq_pkg::DATA_OFS:   rdata_nxt = {16'h0, head_data};
      default:                 rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Data-phase read word
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_req) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Write address held for the data phase
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_req;
      if (wr_req) begin
        wr_addr_r <= HADDR[7:0];
      end
    end
  end

  // Configuration registers; start bit is a self-clearing pulse
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl_r     <= adc_acq_pkg::CTRL_RESET;
      low_r      <= 4'h0;
      high_r     <= 4'h0;
      prog_r     <= adc_acq_pkg::PROG_RESET;
      limit_r    <= adc_acq_pkg::LIMIT_RESET;
      sw_start_r <= 1'b0;
    end else begin
      sw_start_r <= 1'b0;
      if (wr_pend_r) begin
        unique case (wr_addr_r)
          adc_acq_pkg::CTRL_OFS: begin
            ctrl_r     <= {1'b0, HWDATA[7:0]};
            sw_start_r <= HWDATA[adc_acq_pkg::CTRL_START_BIT];
          end
          adc_acq_pkg::CHAN_OFS: begin
            low_r  <= HWDATA[adc_acq_pkg::CHAN_LOW_LSB +: 4];
            high_r <= HWDATA[adc_acq_pkg::CHAN_HIGH_LSB +: 4];
          end
          adc_acq_pkg::PROG_OFS:  prog_r <= HWDATA[7:0];
          // Values above 2048 saturate at the queue depth
          adc_acq_pkg::LIMIT_OFS: limit_r <= (HWDATA[31:11] != 21'h0) ?
                                             12'h800 : HWDATA[11:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source selection
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pin_meta_r <= 3'b000;
      pin_sync_r <= 3'b000;
      pin_last_r <= 3'b000;
    end else begin
      pin_meta_r <= {CTR1_OUT, CTR0_OUT, DIO_D2};
      pin_sync_r <= pin_meta_r;
      pin_last_r <= pin_sync_r;
    end
  end

  always_comb begin
    unique case (adc_acq_pkg::trig_src_t'(ctrl_r[adc_acq_pkg::CTRL_SRC_LSB +: 2]))
      adc_acq_pkg::SRC_SOFTWARE:  trig = sw_start_r;
      adc_acq_pkg::SRC_DIO_FALL:  trig = pin_last_r[0] && !pin_sync_r[0];
      adc_acq_pkg::SRC_CTR0_RISE: trig = !pin_last_r[1] && pin_sync_r[1];
      adc_acq_pkg::SRC_CTR1_RISE: trig = !pin_last_r[2] && pin_sync_r[2];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-microsecond tick divider
  assign tick = (tick_cnt_r == 5'(adc_acq_pkg::TICK_CYCLES - 1));
  always_ff @(posedge SYS_CLK) begin
    if (RESET || tick) begin
      tick_cnt_r <= 5'h00;
    end else begin
      tick_cnt_r <= tick_cnt_r + 5'h01;
    end
  end

  // Step interval in ticks
  always_comb begin
    unique case (ctrl_r[adc_acq_pkg::CTRL_STEP_LSB +: 2])
      2'd0: step_ticks = adc_acq_pkg::STEP_10US_TICKS;
      2'd1: step_ticks = adc_acq_pkg::STEP_12US5_TICKS;
      2'd2: step_ticks = adc_acq_pkg::STEP_20US_TICKS;
      2'd3: step_ticks = 10'({2'b00, prog_r} * adc_acq_pkg::TICKS_PER_US);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition sequencer
  assign last_chan   = !sweep || (chan_r >= high_eff);
  assign sample_done = (state_r == S_WAIT) && CONV_DONE;
  assign sweep_done  = sample_done && last_chan;
  assign q_push      = sample_done;
  assign CONV_START  = (state_r == S_START) && run;
  assign CONV_CHANNEL = chan_r;

  // While run is low: no trigger, no start, no gap count; a conversion in flight still completes and steps the channel
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_r <= S_IDLE;
      chan_r  <= 4'h0;
      gap_r   <= 10'h000;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          chan_r <= low_eff;
          if (run && trig) begin
            state_r <= S_START;
          end
        end
        S_START: begin
          if (run) begin
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (CONV_DONE) begin
            if (last_chan) begin
              chan_r  <= low_eff;
              state_r <= S_IDLE;
            end else begin
              chan_r  <= chan_r + 4'h1;
              gap_r   <= step_ticks;
              state_r <= S_GAP;
            end
          end
        end
        S_GAP: begin
          if (run && tick) begin
            if (gap_r <= 10'h001) begin
              state_r <= S_START;
            end else begin
              gap_r <= gap_r - 10'h001;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue and flags
  assign level_flag = (fill_count >= limit_r);

  sample_queue u_queue (
    .clk        (SYS_CLK),
    .rst        (RESET),
    .push       (q_push),
    .push_data  (CONV_DATA),
    .pop        (q_pop),
    .head_data  (head_data),
    .fill_count (fill_count),
    .full       (q_full),
    .empty      (q_empty)
  );

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      overrun_r <= 1'b0;
      event_r   <= 1'b0;
    end else begin
      if (q_push && q_full) begin
        overrun_r <= 1'b1;
      end else if (wr_pend_r && wr_addr_r == adc_acq_pkg::STATUS_OFS &&
                   HWDATA[adc_acq_pkg::ST_OVERRUN_BIT]) begin
        overrun_r <= 1'b0;
      end
      if (sweep ? sweep_done : sample_done) begin
        event_r <= 1'b1;
      end else if (wr_pend_r && wr_addr_r == adc_acq_pkg::STATUS_OFS &&
                   HWDATA[adc_acq_pkg::ST_EVENT_BIT]) begin
        event_r <= 1'b0;
      end
    end
  end

  // Interrupt source chosen by queue interrupt mode
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ADC_IRQ <= 1'b0;
    end else if (ctrl_r[adc_acq_pkg::CTRL_QIRQ_BIT]) begin
      ADC_IRQ <= level_flag;
    end else begin
      ADC_IRQ <= event_r;
    end
  end

endmodule // adc_acq_ctrl

// ===== rtl/adc_acq_pkg.sv
// Purpose: Shared constants for the converter acquisition and sample queue block
// Assumes: 50 MHz system clock, AHB-Lite register access with 32-bit words
// Notes:   All offsets are byte addresses of aligned words
package adc_acq_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_NS        = 500;                        // Half-microsecond step base
  localparam int TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
  localparam int STEP_10US_NS   = 10000;
  localparam int STEP_12US5_NS  = 12500;
  localparam int STEP_20US_NS   = 20000;
  localparam int US_NS          = 1000;
  localparam logic [9:0] STEP_10US_TICKS  = 10'(STEP_10US_NS / TICK_NS);
  localparam logic [9:0] STEP_12US5_TICKS = 10'(STEP_12US5_NS / TICK_NS);
  localparam logic [9:0] STEP_20US_TICKS  = 10'(STEP_20US_NS / TICK_NS);
  localparam logic [9:0] TICKS_PER_US     = 10'(US_NS / TICK_NS);

  // Queue geometry
  localparam int QUEUE_DEPTH    = 2048;
  localparam int QUEUE_AW       = 11;
  localparam int COUNT_W        = 12;
  localparam int SAMPLE_W       = 16;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] CHAN_OFS     = 8'h04;
  localparam logic [7:0] PROG_OFS     = 8'h08;
  localparam logic [7:0] LIMIT_OFS    = 8'h0c;
  localparam logic [7:0] STATUS_OFS   = 8'h10;
  localparam logic [7:0] DATA_OFS     = 8'h14;

  // Control field positions
  localparam int CTRL_SWEEP_BIT  = 0;
  localparam int CTRL_SRC_LSB    = 1;
  localparam int CTRL_STEP_LSB   = 3;
  localparam int CTRL_QIRQ_BIT   = 5;
  localparam int CTRL_RUN_BIT    = 6;
  localparam int CTRL_DIFF_BIT   = 7;
  localparam int CTRL_START_BIT  = 8;

  // Channel bound field positions
  localparam int CHAN_LOW_LSB    = 0;
  localparam int CHAN_HIGH_LSB   = 8;

  // Status field positions
  localparam int ST_OVERRUN_BIT  = 0;
  localparam int ST_FULL_BIT     = 1;
  localparam int ST_LEVEL_BIT    = 2;
  localparam int ST_EMPTY_BIT    = 3;
  localparam int ST_BUSY_BIT     = 4;
  localparam int ST_EVENT_BIT    = 5;
  localparam int ST_COUNT_LSB    = 16;

  // Reset values
  localparam logic [8:0]  CTRL_RESET  = 9'h000;
  localparam logic [7:0]  PROG_RESET  = 8'h64;
  localparam logic [11:0] LIMIT_RESET = 12'h000;

  // Channel range limits
  localparam logic [3:0] SE_MAX_CHAN   = 4'hf;
  localparam logic [3:0] DIFF_MAX_CHAN = 4'h7;

  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

  typedef enum logic [1:0] {
    SRC_SOFTWARE = 2'd0,
    SRC_DIO_FALL = 2'd1,
    SRC_CTR0_RISE = 2'd2,
    SRC_CTR1_RISE = 2'd3
  } trig_src_t;

endpackage

// ===== rtl/sample_queue.sv
// Purpose: Sample queue of converter results in flip-flop storage
// Assumes: Push and pop from the same clock; pop ignored when empty
// Notes:   A push while full is dropped and reported by the caller
`timescale 1ns/100ps
module sample_queue (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst,
  // Write side
  input  wire logic                              push,
  input  wire logic [adc_acq_pkg::SAMPLE_W-1:0]  push_data,
  // Read side
  input  wire logic                              pop,
  output logic      [adc_acq_pkg::SAMPLE_W-1:0]  head_data,
  // Fill state
  output logic      [adc_acq_pkg::COUNT_W-1:0]   fill_count,
  output logic                                   full,
  output logic                                   empty
);

  logic [adc_acq_pkg::SAMPLE_W-1:0] mem [adc_acq_pkg::QUEUE_DEPTH];
  logic [adc_acq_pkg::QUEUE_AW-1:0] wr_ptr_r;
  logic [adc_acq_pkg::QUEUE_AW-1:0] rd_ptr_r;
  logic [adc_acq_pkg::COUNT_W-1:0]  count_r;
  logic                             do_push;
  logic                             do_pop;

  assign full       = (count_r == adc_acq_pkg::COUNT_W'(adc_acq_pkg::QUEUE_DEPTH));
  assign empty      = (count_r == '0);
  assign do_push    = push && !full;
  assign do_pop     = pop && !empty;
  assign head_data  = mem[rd_ptr_r];
  assign fill_count = count_r;

  // Storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + 1'b1;
      end else if (do_pop && !do_push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule // sample_queue

// ===== testbench/adc_acq_ctrl_sva.sv
// Purpose: Port-level checks on the acquisition controller
// Assumes: Zero-wait bus slave, read data latched at the address-phase edge
// Notes:   Bound into every adc_acq_ctrl instance
`timescale 1ns/100ps
module adc_acq_ctrl_chk (
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  // Bus
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic [31:0] HRDATA,
  // Converter
  input wire logic        CONV_START,
  input wire logic [3:0]  CONV_CHANNEL,
  input wire logic        CONV_DONE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic busy_r;
  ////////////////////////////////////////////////////////////////////////
  // Tracks a conversion in flight between start and done
  always_ff @(posedge SYS_CLK) begin
    if (RESET)
      busy_r <= 1'b0;
    else if (CONV_START)
      busy_r <= 1'b1;
    else if (CONV_DONE)
      busy_r <= 1'b0;
  end
  sequence rd_taken;
    HSEL && HREADY && HTRANS[1] && !HWRITE;
  endsequence
  sequence st_rd;
    rd_taken ##0 (HADDR[7:0] == adc_acq_pkg::STATUS_OFS);
  endsequence
  a_bus_okay:     assert property (HREADYOUT && !HRESP)
    else $error("bus slave not ready or not okay");
  a_start_pulse:  assert property (CONV_START |=> !CONV_START)
    else $error("start held longer than one cycle");
  a_no_restart:   assert property (busy_r |-> !CONV_START)
    else $error("start while a conversion is in flight");
  a_chan_held:    assert property (busy_r |-> $stable(CONV_CHANNEL))
    else $error("channel moved during a conversion");
  a_step_gap:     assert property (CONV_DONE |=> !CONV_START [*4])
    else $error("next channel started without an interval");
  a_unmapped_rd:  assert property ((rd_taken ##0 (HADDR[7:0] > 8'h14)) |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_empty_count:  assert property (st_rd |=> HRDATA[3] == (HRDATA[27:16] == 12'h000))
    else $error("empty flag disagrees with count");
  a_full_count:   assert property (st_rd |=> HRDATA[1] == (HRDATA[27:16] == 12'h800))
    else $error("full flag disagrees with count");
  a_count_range:  assert property (st_rd |=> HRDATA[27:16] <= 12'h800)
    else $error("fill count above queue depth");
endmodule // adc_acq_ctrl_chk

bind adc_acq_ctrl adc_acq_ctrl_chk u_chk (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .HRDATA(HRDATA), .CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL),
  .CONV_DONE(CONV_DONE));

// ===== testbench/conv_core_model.sv
// Purpose: Behavioural converter core answering start with a done pulse
// Assumes: Same clock as the controller
// Notes:   Result carries the channel so the bench can tell samples apart
`timescale 1ns/100ps
module conv_core_model #(
  parameter int LATENCY = 3
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Converter handshake
  input  wire logic        start,
  input  wire logic [3:0]  channel,
  output logic             done,
  output logic      [15:0] data
);
  logic [7:0] wait_r;
  logic [3:0] chan_r;
  ////////////////////////////////////////////////////////////////////////
  // Data churns outside done so a stale value is never mistaken for a result
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_r <= 8'h00;
      done   <= 1'b0;
      data   <= 16'h5555;
    end else begin
      done <= (wait_r == 8'h01);
      data <= (wait_r == 8'h01) ? {12'ha50, chan_r} : ~data;
      if (start) begin
        wait_r <= 8'(LATENCY);
        chan_r <= channel;
      end else if (wait_r != 8'h00) begin
        wait_r <= wait_r - 8'h01;
      end
    end
  end
endmodule // conv_core_model

// ===== testbench/test_adc_acq_ctrl.sv
// Purpose: Register-level bench of the acquisition controller
// Assumes: Bus master task of single word transfers, converter model attached
// Notes:   Busy and event bits are masked out of status compares
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_adc_acq_ctrl;
  localparam logic [31:0] RUN = 32'h0000_0040;
  localparam logic [31:0] GO  = 32'h0000_0100;
  localparam logic [31:0] M   = 32'hffff_ffcf;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  localparam logic [31:0] LO  = 32'h0000_ffff;
  logic        sys_clk, reset, hsel, hwrite, dio_d2, ctr0_out, ctr1_out;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  wire logic   hreadyout, hresp, conv_start, conv_done, adc_irq;
  wire logic [31:0] hrdata;
  wire logic [3:0]  conv_channel;
  wire logic [15:0] conv_data;
  int err_count, checked, cyc;
  int gap_cyc, last_gap, gap_slack;
  adc_acq_ctrl u_dut (.SYS_CLK(sys_clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .DIO_D2(dio_d2),
    .CTR0_OUT(ctr0_out), .CTR1_OUT(ctr1_out), .CONV_START(conv_start),
    .CONV_CHANNEL(conv_channel), .CONV_DONE(conv_done), .CONV_DATA(conv_data),
    .ADC_IRQ(adc_irq));
  conv_core_model u_conv (.clk(sys_clk), .rst(reset), .start(conv_start),
    .channel(conv_channel), .done(conv_done), .data(conv_data));
  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; fill test dominates run time
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  // Cycles from a done to the next start; the step interval is judged on it
  always @(posedge sys_clk) begin
    gap_cyc <= conv_done ? 0 : gap_cyc + 1;
    if (conv_start)
      last_gap <= gap_cyc;
  end
  task report_and_stop;
    $display("Checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One transfer; waits on ready in both phases, read data taken at the second
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= adc_acq_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string n);
    ahb(1'b0, a, 32'h0);
    `CHK(n, e, rd & m)
  endtask
  task automatic wait_cnt(input logic [11:0] n);
    do ahb(1'b0, adc_acq_pkg::STATUS_OFS, 32'h0); while (rd[27:16] !== n);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    {dio_d2, ctr0_out, ctr1_out} = 3'b100;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(adc_acq_pkg::STATUS_OFS, M, 32'h0000_000c, "reset status");
    rchk(8'h20, ALL, 32'h0, "unmapped");
    rchk(adc_acq_pkg::LIMIT_OFS, ALL, 32'h0, "reset limit");
    rchk(adc_acq_pkg::PROG_OFS, ALL, {24'h0, adc_acq_pkg::PROG_RESET}, "reset prog");
    // Start while stopped must not convert
    ahb(1'b1, adc_acq_pkg::CTRL_OFS, GO);
    repeat (20) @(posedge sys_clk);
    rchk(adc_acq_pkg::STATUS_OFS, M, 32'h0000_000c, "stopped");
    ahb(1'b1, adc_acq_pkg::CHAN_OFS, 32'h0000_0903);
    ahb(1'b1, adc_acq_pkg::CTRL_OFS, RUN | GO);
    wait_cnt(12'h001);
    repeat (3) @(posedge sys_clk);
    `CHK("irq single", 1'b1, adc_irq)
    rchk(adc_acq_pkg::DATA_OFS, LO, 32'ha503, "single");
    ahb(1'b1, adc_acq_pkg::STATUS_OFS, 32'h20);
    repeat (3) @(posedge sys_clk);
    `CHK("irq cleared", 1'b0, adc_irq)
    // Two sweeps of channels 2..5 at step codes 0 and 1; the second restarts at low
    ahb(1'b1, adc_acq_pkg::CHAN_OFS, 32'h0000_0502);
    for (int r = 0; r < 2; r++) begin
      ahb(1'b1, adc_acq_pkg::CTRL_OFS, RUN | GO | 32'h1 | (r << 3));
      wait_cnt(12'(4 * r + 1));
      `CHK("irq mid sweep", 1'b0, adc_irq)
      wait_cnt(12'(4 * r + 4));
      repeat (40) @(posedge sys_clk);
      rchk(adc_acq_pkg::STATUS_OFS, M, {4'h0, 12'(4 * r + 4), 16'h0004}, "sweep");
      `CHK("irq sweep", 1'b1, adc_irq)
      // Tick phase is free, so the gap may fall short by up to one tick
      gap_slack = (r == 0 ? adc_acq_pkg::STEP_10US_NS : adc_acq_pkg::STEP_12US5_NS) /
                  adc_acq_pkg::CLK_PERIOD_NS - last_gap;
      `CHK("step gap", 1'b1, gap_slack inside {[0:adc_acq_pkg::TICK_CYCLES - 1]})
      ahb(1'b1, adc_acq_pkg::STATUS_OFS, 32'h20);
    end
    ahb(1'b1, adc_acq_pkg::LIMIT_OFS, 32'h8);
    ahb(1'b1, adc_acq_pkg::CTRL_OFS, RUN | 32'h20);
    repeat (3) @(posedge sys_clk);
    `CHK("irq level", 1'b1, adc_irq)
    for (int i = 0; i < 8; i++) begin
      rchk(adc_acq_pkg::DATA_OFS, LO, 32'ha502 + i % 4, "sweep data");
      repeat (3) @(posedge sys_clk);
      `CHK("irq below", 1'b0, adc_irq)
    end
    rchk(adc_acq_pkg::STATUS_OFS, M, 32'h0000_0008, "drained");
    // Pin trigger sources, each edge once, reverse edge ignored
    for (int s = 1; s < 4; s++) begin
      ahb(1'b1, adc_acq_pkg::CHAN_OFS, 32'h8 + s);
      ahb(1'b1, adc_acq_pkg::CTRL_OFS, RUN | (s << 1));
      @(posedge sys_clk);
      {dio_d2, ctr0_out, ctr1_out} <= {s != 1, s == 2, s == 3};
      wait_cnt(12'h001);
      {dio_d2, ctr0_out, ctr1_out} <= 3'b100;
      rchk(adc_acq_pkg::DATA_OFS, LO, 32'ha508 + s, "source");
      repeat (20) @(posedge sys_clk);
      rchk(adc_acq_pkg::STATUS_OFS, M, 32'h0000_0008, "source idle");
    end
    // Fill to full in differential mode, then overrun
    ahb(1'b1, adc_acq_pkg::LIMIT_OFS, 32'hfff);
    rchk(adc_acq_pkg::LIMIT_OFS, ALL, 32'h800, "limit sat");
    for (int i = 0; i < 2048; i++) begin
      ahb(1'b1, adc_acq_pkg::CTRL_OFS, RUN | GO | 32'h80);
      wait_cnt(12'(i + 1));
    end
    rchk(adc_acq_pkg::STATUS_OFS, M, 32'h0800_0006, "full");
    ahb(1'b1, adc_acq_pkg::CTRL_OFS, RUN | GO | 32'h80);
    do ahb(1'b0, adc_acq_pkg::STATUS_OFS, 32'h0); while (rd[0] !== 1'b1);
    rchk(adc_acq_pkg::STATUS_OFS, M, 32'h0800_0007, "overrun");
    rchk(adc_acq_pkg::DATA_OFS, LO, 32'ha503, "diff chan");
    rchk(adc_acq_pkg::STATUS_OFS, M, 32'h07ff_0001, "popped");
    report_and_stop();
  end
endmodule // test_adc_acq_ctrl
